//--- hdl/msp_edge_sync.sv
// synchroniser plus edge detector for one phase input
// assumes input is already synchronous-ish; two flops stabilise it
`timescale 1ns/10ps
module msp_edge_sync (
    input wire logic clk_in, // peripheral clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic d_in, // raw phase input
    output logic level_out, // synchronised level
    output logic rise_out, // one-cycle rising pulse
    output logic fall_out // one-cycle falling pulse
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    assign level_out = sync_ff;
    assign rise_out = sync_ff & ~prev_ff; // RULE21
    assign fall_out = ~sync_ff & prev_ff; // RULE21
endmodule // msp_edge_sync

//--- hdl/msp_input_stage.sv
// motor input stage: sampling mode select, noise filter, tacho and encoder paths
// assumes pwm_on_in, commutation_in synchronous to sys_clk_in
// Operation
// RULE1: 1 us blanking after every pwm edge
// RULE2: one 1 MHz sample after edge dropped
// RULE3: filter on for D; Z only high-rate, no delay
// RULE4: default mode: Z at end of off time
// RULE5: high-rate no delay: D and Z continuous
// RULE6: delay set: Z sampled only during on time
// RULE7: sensor mode: Z continuous, no filters, os1 off
// RULE8: sensorless applies window and event filters
// RULE9: speed sensor when edge select nonzero
// RULE10: tacho mux routes one chosen phase input
// RULE11: edge select rising, falling or both
// RULE12: 01 rising, 10 falling, 11 both
// RULE13: input select preloaded until commutation event
// RULE14: software uses direct access at init
// RULE15: encoder signals on inputs a and b
// RULE16: encoder clock on all four edges
// RULE17: direction from relative quadrature phase
// RULE18: direction never changes timer count direction
// RULE19: direction samples a on b falling
// RULE20: single input still gives half-rate clock
// RULE21: synchronised inputs, one pulse per edge
`timescale 1ns/10ps
module msp_input_stage #(
    parameter int FILT_CYC = msp_pkg::NOISE_FILTER_CYC,
    parameter int DIV_CYC = msp_pkg::SAMPLE_DIV_CYC,
    parameter int STEP_CYC = msp_pkg::DELAY_STEP_CYC
) (
    input wire logic sys_clk_in, // 10 MHz clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic phase_input_a_in, // phase input a
    input wire logic phase_input_b_in, // phase input b
    input wire logic phase_input_c_in, // phase input c
    input wire logic pwm_on_in, // pwm level, high = on
    input wire logic commutation_in, // commutation event pulse
    input wire logic d_detected_in, // d event seen, z phase active
    input wire logic sensor_mode_sel_in, // 1 = position sensors
    input wire logic high_rate_sampling_select_in, // z at sampling clock
    input wire logic [3:0] sample_delay_sel_in, // delay steps of 2.5 us
    input wire logic [1:0] tacho_edge_sel_in, // speed sensor edge select
    input wire logic [1:0] input_sel_in, // requested input select
    input wire logic input_sel_wr_in, // write strobe for input_sel
    input wire logic direct_access_ctl_in, // apply input_sel at once
    output logic d_sample_out, // d sample strobe
    output logic z_sample_out, // z sample strobe
    output logic sample_out_of_on_out, // delayed sample fell in off time
    output logic filters_enable_out, // window/event filters in use
    output logic os1_enable_out, // output_behaviour_sel bit 1 usable
    output logic speed_mode_out, // speed sensor mode active
    output logic [1:0] input_sel_out, // active input select
    output logic capture_out, // tacho or encoder clock pulse
    output logic encoder_direction_out, // encoder direction, read only
    output logic [2:0] phase_level_out // synchronised phase levels
);
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [$clog2(DIV_CYC+1)-1:0] div_ff;
    logic [$clog2(FILT_CYC+1)-1:0] filt_ff;
    // wide enough for the longest delay step count
    localparam int DLY_W = $bits(sample_delay_sel_in) + $clog2(STEP_CYC + 1);
    logic [DLY_W-1:0] dly_ff;
    logic dly_done;
    logic pwm_ff;
    logic [1:0] is_ff;
    logic [1:0] is_pre_ff;
    logic dir_ff;
    msp_pkg::msp_dly_state_t dly_st_ff;
    logic tick;
    logic pwm_edge;
    logic blank;
    logic delayed;
    logic filt_z;
    logic z_raw;
    logic cap_nxt;

    genvar g;
    for (g = 0; g < 3; g++) begin : g_ph
        msp_edge_sync u_sync (
            .clk_in(sys_clk_in),
            .rst_n_in(rst_n_in),
            .d_in(g == 0 ? phase_input_a_in : (g == 1 ? phase_input_b_in : phase_input_c_in)),
            .level_out(lvl[g]),
            .rise_out(rise[g]),
            .fall_out(fall[g])
        );
    end

    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        edge_pick = (sel[0] & r) | (sel[1] & f); // RULE12
    endfunction

    // sampling clock divider
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_ff <= '0;
        end else if (div_ff == ($bits(div_ff))'(DIV_CYC - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign tick = (div_ff == ($bits(div_ff))'(DIV_CYC - 1));

    // pwm edge noise blanking window
    assign pwm_edge = pwm_on_in ^ pwm_ff;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_ff <= 1'b0;
            filt_ff <= '0;
        end else begin
            pwm_ff <= pwm_on_in;
            if (pwm_edge) begin
                // edge cycle is the first blanked one, so exactly one tick falls inside
                filt_ff <= ($bits(filt_ff))'(FILT_CYC - 1); // RULE1
            end else if (filt_ff != '0) begin
                filt_ff <= filt_ff - 1'b1;
            end
        end
    end
    assign blank = pwm_edge | (filt_ff != '0); // RULE2

    // delay before on-time sampling
    assign delayed = (sample_delay_sel_in != msp_pkg::DELAY_NONE);
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dly_st_ff <= msp_pkg::MSP_DLY_IDLE;
            dly_ff <= '0;
        end else begin
            case (dly_st_ff)
                msp_pkg::MSP_DLY_IDLE: begin
                    if (pwm_edge && pwm_on_in && delayed) begin
                        dly_st_ff <= msp_pkg::MSP_DLY_WAIT;
                        dly_ff <= DLY_W'(sample_delay_sel_in * STEP_CYC);
                    end
                end
                msp_pkg::MSP_DLY_WAIT: begin
                    // pwm went off before the delay ran out: give up this period
                    if (pwm_edge) begin
                        dly_st_ff <= msp_pkg::MSP_DLY_IDLE;
                    end else if (dly_ff > DLY_W'(1)) begin
                        dly_ff <= dly_ff - DLY_W'(1);
                    end else begin
                        dly_st_ff <= msp_pkg::MSP_DLY_OPEN;
                    end
                end
                msp_pkg::MSP_DLY_OPEN: begin
                    if (!high_rate_sampling_select_in || !pwm_on_in) begin
                        dly_st_ff <= msp_pkg::MSP_DLY_IDLE;
                    end
                end
                default: dly_st_ff <= msp_pkg::MSP_DLY_IDLE;
            endcase
        end
    end

    // z sample source by mode
    assign dly_done = (dly_st_ff == msp_pkg::MSP_DLY_WAIT) && (dly_ff == DLY_W'(1));
    assign filt_z = high_rate_sampling_select_in && !delayed; // RULE3
    always_comb begin
        if (sensor_mode_sel_in) begin
            z_raw = tick; // RULE7
        end else if (!delayed) begin
            z_raw = high_rate_sampling_select_in ? (tick && !blank) // RULE5
                                                 : (pwm_edge && pwm_on_in); // RULE4
        end else begin
            z_raw = high_rate_sampling_select_in ? (tick && dly_st_ff == msp_pkg::MSP_DLY_OPEN)
                                                 : dly_done; // RULE6
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            d_sample_out <= 1'b0;
            z_sample_out <= 1'b0;
            sample_out_of_on_out <= 1'b0;
            filters_enable_out <= 1'b0;
            os1_enable_out <= 1'b1;
        end else begin
            d_sample_out <= !sensor_mode_sel_in && !d_detected_in && tick && !blank; // RULE3
            z_sample_out <= (d_detected_in || sensor_mode_sel_in) && z_raw // RULE7
                            && (pwm_on_in || !delayed || sensor_mode_sel_in)
                            && !(filt_z && !sensor_mode_sel_in && blank);
            sample_out_of_on_out <= !sensor_mode_sel_in && !pwm_on_in && pwm_edge
                                    && dly_st_ff == msp_pkg::MSP_DLY_WAIT; // RULE6
            filters_enable_out <= !sensor_mode_sel_in; // RULE8
            os1_enable_out <= !sensor_mode_sel_in; // RULE7
        end
    end

    // input select preload
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            is_pre_ff <= 2'h0;
            is_ff <= 2'h0;
        end else begin
            if (input_sel_wr_in) begin
                is_pre_ff <= input_sel_in;
            end
            if (input_sel_wr_in && direct_access_ctl_in) begin
                is_ff <= input_sel_in; // RULE13
            end else if (commutation_in) begin
                is_ff <= input_sel_wr_in ? input_sel_in : is_pre_ff; // RULE13
            end
        end
    end

    // tacho and encoder edges; timer counts up whatever the direction
    always_comb begin
        if (is_ff == msp_pkg::INPUT_ENCODER) begin
            cap_nxt = rise[0] | fall[0] | rise[1] | fall[1]; // RULE16 RULE20
        end else begin
            cap_nxt = edge_pick(tacho_edge_sel_in, rise[is_ff], fall[is_ff]); // RULE10 RULE11
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_ff <= 1'b0;
        end else if (is_ff == msp_pkg::INPUT_ENCODER && fall[1]) begin
            dir_ff <= lvl[0]; // RULE17 RULE19
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capture_out <= 1'b0;
            speed_mode_out <= 1'b0;
            input_sel_out <= 2'h0;
            encoder_direction_out <= 1'b0;
            phase_level_out <= 3'h0;
        end else begin
            speed_mode_out <= (tacho_edge_sel_in != msp_pkg::EDGE_NONE); // RULE9
            capture_out <= (tacho_edge_sel_in != msp_pkg::EDGE_NONE) && cap_nxt; // RULE18 RULE21
            input_sel_out <= is_ff;
            encoder_direction_out <= dir_ff;
            phase_level_out <= lvl;
        end
    end
endmodule // msp_input_stage

//--- hdl/msp_pkg.sv
// constants for the motor input sampling and speed sensor block
// assumes a single 10 MHz peripheral clock
package msp_pkg;
    localparam int CLK_FREQ_HZ = 10000000;
    localparam int NOISE_FILTER_NS = 1000;
    localparam int NOISE_FILTER_CYC = (NOISE_FILTER_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam int SAMPLE_FREQ_HZ = 1000000;
    localparam int SAMPLE_DIV_CYC = CLK_FREQ_HZ / SAMPLE_FREQ_HZ;
    localparam int DELAY_STEP_NS = 2500;
    localparam int DELAY_STEP_CYC = (DELAY_STEP_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] INPUT_ENCODER = 2'h3;
    localparam logic [3:0] DELAY_NONE = 4'h0;
    typedef enum logic [1:0] {
        MSP_DLY_IDLE = 2'b00,
        MSP_DLY_WAIT = 2'b01,
        MSP_DLY_OPEN = 2'b11
    } msp_dly_state_t;
endpackage

//--- verification/msp_input_stage_asserts.sv
// port checker for the motor input stage
// assumes it is bound onto msp_input_stage
`timescale 1ns/10ps
module msp_input_stage_asserts (
    input wire logic sys_clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic phase_input_a_in, // phase a
    input wire logic phase_input_b_in, // phase b
    input wire logic pwm_on_in, // pwm level
    input wire logic commutation_in, // c event
    input wire logic sensor_mode_sel_in, // sensor mode
    input wire logic direct_access_ctl_in, // direct access
    input wire logic [1:0] tacho_edge_sel_in, // edge select
    input wire logic d_sample_out, // d strobe
    input wire logic filters_enable_out, // filters on
    input wire logic os1_enable_out, // os1 usable
    input wire logic speed_mode_out, // speed mode
    input wire logic [1:0] input_sel_out, // active select
    input wire logic capture_out, // capture pulse
    input wire logic encoder_direction_out // direction
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic enc;
    assign enc = input_sel_out == 2'h3 && tacho_edge_sel_in != 2'h0;
    AST_NOISE_D: assert property ($changed(pwm_on_in) |-> ##3 !d_sample_out [*8])
        else $error("d sample inside noise window");
    AST_SPEED: assert property ($past(rst_n_in) |-> speed_mode_out == ($past(tacho_edge_sel_in) != 2'h0))
        else $error("speed mode wrong");
    AST_OS1: assert property ($past(rst_n_in) |-> os1_enable_out == !$past(sensor_mode_sel_in))
        else $error("os1 enable wrong");
    AST_FILT: assert property ($past(rst_n_in) |-> filters_enable_out == !$past(sensor_mode_sel_in))
        else $error("filter enable wrong");
    AST_GATE: assert property ((tacho_edge_sel_in == 2'h0) [*5] |-> !capture_out)
        else $error("capture without edge select");
    AST_ENC_CLK: assert property (enc && ($changed(phase_input_a_in) || $changed(phase_input_b_in)) |-> ##3 capture_out)
        else $error("encoder edge lost");
    AST_ONE_PULSE: assert property (enc && $stable(phase_input_a_in) && $stable(phase_input_b_in) |-> ##3 !capture_out)
        else $error("spurious encoder pulse");
    AST_DIR: assert property (enc && $fell(phase_input_b_in) |-> ##5 encoder_direction_out == $past(phase_input_a_in, 5))
        else $error("direction not a at b fall");
    AST_PRELOAD: assert property ($changed(input_sel_out) |->
        $past(direct_access_ctl_in) || $past(commutation_in) || $past(commutation_in, 2) || $past(commutation_in, 3))
        else $error("input select changed early");
    cover property (enc && capture_out);
    cover property (enc && $fell(phase_input_b_in));
    cover property (commutation_in ##[1:3] $changed(input_sel_out));
endmodule // msp_input_stage_asserts

bind msp_input_stage msp_input_stage_asserts u_asserts (.sys_clk_in, .rst_n_in, .phase_input_a_in, .phase_input_b_in,
    .pwm_on_in, .commutation_in, .sensor_mode_sel_in, .direct_access_ctl_in, .tacho_edge_sel_in, .d_sample_out,
    .filters_enable_out, .os1_enable_out, .speed_mode_out, .input_sel_out, .capture_out, .encoder_direction_out);

//--- verification/msp_input_stage_tb.sv
// self-checking bench for msp_input_stage
// assumes the sensor model drives the phase inputs
`timescale 1ns/10ps
module msp_input_stage_tb;
    logic sys_clk_in = 1'h0, rst_n_in = 1'h0, pwm_on_in = 1'h0, commutation_in = 1'h0, d_detected_in = 1'h0;
    logic sensor_mode_sel_in = 1'h0, high_rate_sampling_select_in = 1'h0, input_sel_wr_in = 1'h0;
    logic direct_access_ctl_in = 1'h0, run = 1'h0, dir = 1'h1, one = 1'h0, exp_dir = 1'h0;
    logic [3:0] sample_delay_sel_in = 4'h0;
    logic [1:0] tacho_edge_sel_in = 2'h0, input_sel_in = 2'h0, act_sel = 2'h0, input_sel_out;
    logic phase_input_a_in, phase_input_b_in, phase_input_c_in, d_sample_out, z_sample_out, sample_out_of_on_out;
    logic filters_enable_out, os1_enable_out, speed_mode_out, capture_out, encoder_direction_out;
    logic [2:0] phase_level_out, prev = 3'h0;
    int mismatches = 0, checked = 0, exp_cap = 0, got_cap = 0, cycles = 0;
    logic exp_d = 1'h0, exp_z = 1'h0, exp_o = 1'h0, pwm_prev = 1'h0, tk, bl, ez;
    int quiet = 1000, tgt = -1, tck = 0;
    msp_input_stage uut (.sys_clk_in, .rst_n_in, .phase_input_a_in, .phase_input_b_in, .phase_input_c_in, .pwm_on_in,
        .commutation_in, .d_detected_in, .sensor_mode_sel_in, .high_rate_sampling_select_in, .sample_delay_sel_in,
        .tacho_edge_sel_in, .input_sel_in, .input_sel_wr_in, .direct_access_ctl_in, .d_sample_out, .z_sample_out,
        .sample_out_of_on_out, .filters_enable_out, .os1_enable_out, .speed_mode_out, .input_sel_out, .capture_out,
        .encoder_direction_out, .phase_level_out);
    msp_sensor_model model (.clk_in(sys_clk_in), .run_in(run), .dir_in(dir), .one_in(one),
        .a_out(phase_input_a_in), .b_out(phase_input_b_in), .c_out(phase_input_c_in));
    initial forever #50 sys_clk_in = ~sys_clk_in;
    function automatic int edges(input logic [2:0] p, input logic [2:0] n);
        logic r, f;
        r = !p[act_sel] && n[act_sel];
        f = p[act_sel] && !n[act_sel];
        if (tacho_edge_sel_in == 2'h0) return 0;
        if (act_sel == 2'h3) return int'(p[0] != n[0]) + int'(p[1] != n[1]);
        return int'(tacho_edge_sel_in[0] & r | tacho_edge_sel_in[1] & f);
    endfunction
    // reference model plus pwm and sampling-mode stimulus
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            end_of_test;
        end
        if (cycles % 37 == 0) begin
            pwm_on_in <= !pwm_on_in;
            {high_rate_sampling_select_in, d_detected_in, sample_delay_sel_in} <= 6'($urandom);
        end
        prev <= {phase_input_c_in, phase_input_b_in, phase_input_a_in};
        got_cap <= got_cap + int'(capture_out);
        exp_cap <= exp_cap + edges(prev, {phase_input_c_in, phase_input_b_in, phase_input_a_in});
        if (act_sel == 2'h3 && prev[1] && !phase_input_b_in) exp_dir <= prev[0];
        // sampling reference: tick phase follows reset, ages counted from pwm edges
        if (rst_n_in) begin
            check(d_sample_out, exp_d);
            check(z_sample_out, exp_z);
            check(sample_out_of_on_out, exp_o);
            quiet++;
            tk = (tck == msp_pkg::SAMPLE_DIV_CYC - 1);
            exp_o <= !sensor_mode_sel_in && pwm_prev && !pwm_on_in && tgt >= 0 && quiet <= tgt;
            if (pwm_on_in != pwm_prev) quiet = 0;
            if (!pwm_on_in) tgt = -1;
            else if (!pwm_prev)
                tgt = (sample_delay_sel_in == 4'h0) ? -1 : int'(sample_delay_sel_in) * msp_pkg::DELAY_STEP_CYC;
            pwm_prev = pwm_on_in;
            bl = (quiet < msp_pkg::NOISE_FILTER_CYC);
            if (sensor_mode_sel_in) ez = tk;
            else if (sample_delay_sel_in == 4'h0)
                ez = high_rate_sampling_select_in ? tk && !bl : pwm_on_in && quiet == 0;
            else
                ez = tgt >= 0 && (high_rate_sampling_select_in ? tk && quiet > tgt : quiet == tgt);
            exp_z <= ez && (d_detected_in || sensor_mode_sel_in);
            exp_d <= !sensor_mode_sel_in && !d_detected_in && tk && !bl;
            tck = (tck + 1) % msp_pkg::SAMPLE_DIV_CYC;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic load_sel(input logic [1:0] s, input logic direct);
        direct_access_ctl_in <= direct;
        input_sel_in <= s;
        input_sel_wr_in <= 1'h1;
        tick(1);
        input_sel_wr_in <= 1'h0;
        tick(4);
        if (!direct) begin
            check(input_sel_out, act_sel);
            commutation_in <= 1'h1;
            tick(1);
            commutation_in <= 1'h0;
            tick(4);
        end
        act_sel = s;
        check(input_sel_out, s);
    endtask
    task automatic spin(input int steps);
        run <= 1'h1;
        tick(16 * steps);
        run <= 1'h0;
        tick(12);
        check(got_cap, exp_cap);
        check(phase_level_out, {phase_input_c_in, phase_input_b_in, phase_input_a_in});
    endtask
    task automatic end_of_test;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h394A));
        tick(12);
        rst_n_in <= 1'h1;
        tick(2);
        load_sel(2'h3, 1'h1);
        for (int t = 0; t < 4; t++) begin
            tacho_edge_sel_in <= 2'(t);
            tick(2);
            check(speed_mode_out, t != 0);
        end
        for (int m = 0; m < 2; m++) begin
            sensor_mode_sel_in <= 1'(m);
            tick(2);
            check({filters_enable_out, os1_enable_out}, (m != 0) ? 2'h0 : 2'h3);
        end
        for (int k = 0; k < 6; k++) begin
            tacho_edge_sel_in <= 2'($urandom_range(3, 1));
            dir <= 1'($urandom);
            one <= k > 3;
            spin(8);
            check(encoder_direction_out, exp_dir);
            if (!one) check(encoder_direction_out, dir);
        end
        one <= 1'h0;
        sensor_mode_sel_in <= 1'h0;
        for (int s = 0; s < 3; s++) begin
            load_sel(2'(s), 1'h0);
            for (int e = 0; e < 4; e++) begin
                tacho_edge_sel_in <= 2'(e);
                spin(4);
            end
        end
        end_of_test;
    end
endmodule // msp_input_stage_tb

//--- verification/msp_sensor_model.sv
// quadrature encoder and tacho model driving the phase inputs
// assumes it is stepped from the block clock
`timescale 1ns/10ps
module msp_sensor_model (
    input wire logic clk_in, // block clock
    input wire logic run_in, // shaft turning
    input wire logic dir_in, // 1 = forward
    input wire logic one_in, // only phase a wired
    output logic a_out, // phase a
    output logic b_out, // phase b
    output logic c_out // phase c
);
    logic [1:0] q_ff = 2'h0;
    logic [3:0] cnt_ff = 4'h0;
    always_ff @(posedge clk_in) begin
        cnt_ff <= run_in ? cnt_ff + 4'h1 : 4'h0;
        if (run_in && cnt_ff == 4'hF)
            q_ff <= dir_in ? q_ff + 2'h1 : q_ff - 2'h1;
    end
    // gray order keeps a and b a quarter period apart
    assign a_out = q_ff[1];
    assign b_out = !one_in && (q_ff[1] ^ q_ff[0]);
    assign c_out = q_ff[0];
endmodule // msp_sensor_model
